// ===== core/gpp_pkg.sv
package gpp_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] SFR_DATA_A = 8'h80;
    localparam logic [7:0] SFR_DATA_B = 8'h90;
    localparam logic [7:0] SFR_DIR_B = 8'h91;
    localparam logic [7:0] SFR_DATA_C = 8'ha0;
    localparam logic [7:0] SFR_DIR_C = 8'ha1;
    localparam logic [7:0] SFR_DIR_A = 8'ha2;

    // ****************************************
    // Reset values and field positions
    // ****************************************
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [4:0] SEG_COUNT_RESET = 5'h00;
    localparam int NUM_PINS = 12;
    localparam int HOOK_PINS = 8;
    localparam int HOOK_FIRST = 4;

    // ****************************************
    // Selector encoding
    // ****************************************
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_RESERVED = 3'h1;
    localparam logic [2:0] SEL_CNT0 = 3'h2;
    localparam logic [2:0] SEL_CNT1 = 3'h3;
    localparam logic [2:0] SEL_HI_RISE = 3'h4;
    localparam logic [2:0] SEL_LO_RISE = 3'h5;
    localparam logic [2:0] SEL_HI_FALL = 3'h6;
    localparam logic [2:0] SEL_LO_FALL = 3'h7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gpp_sfr_req_t;

    typedef struct packed {
        logic counter_zero_clock;
        logic counter_one_clock;
        logic hi_prio_irq_line;
        logic lo_prio_irq_line;
    } gpp_hooks_t;

endpackage

// ===== core/gpp_port.sv
`timescale 1ns/100ps
module gpp_port #(
    parameter int SYNC_STAGES = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire gpp_pkg::gpp_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic [4:0] segment_count_select,
    input wire logic [23:0] pin_hook_select,
    input wire logic energy_pulse_enable,
    input wire logic reactive_pulse_enable,
    input wire logic eeprom_pin_select,
    input wire logic energy_pulse_out,
    input wire logic reactive_pulse_out,
    input wire logic [1:0] eeprom_out,
    input wire logic [1:0] eeprom_oe,
    output logic [1:0] eeprom_in,
    input wire logic irq0_ack,
    input wire logic irq1_ack,
    input wire logic [11:0] gp_pin_in,
    output logic [11:0] gp_pin_out,
    output logic [11:0] gp_pin_oe,
    output logic [11:0] lcd_claim,
    output gpp_pkg::gpp_hooks_t hooks,
    output logic irq0_flag,
    output logic irq1_flag
);

    // ****************************************
    // Elaboration check
    // ****************************************
    if (SYNC_STAGES != 3) begin : g_bad
        $error("Pin synchroniser must have three stages");
    end

    // Pin index i: 0..7 are pins 4..11, 8..11 are pins 14..17
    logic [7:0] data_a_q, data_b_q, data_c_q;
    logic [7:0] dir_a_q, dir_b_q, dir_c_q;
    logic [11:0] s1_q, s2_q, s3_q, lvl_q;
    logic [11:0] dout, dir;
    logic [11:0] claim;
    gpp_pkg::gpp_hooks_t hooks_d;
    logic hi_prev_rise_q, hi_prev_fall_q, lo_prev_rise_q, lo_prev_fall_q;
    logic hi_rise, hi_fall, lo_rise, lo_fall;
    logic [11:0] pin_out_d, pin_oe_d;

    assign dout = {data_c_q[1:0], data_b_q[7:6], data_b_q[3:0], data_a_q[7:4]};
    assign dir = {dir_c_q[1:0], dir_b_q[7:6], dir_b_q[3:0], dir_a_q[7:4]};

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_a_q <= gpp_pkg::DIR_RESET;
            dir_b_q <= gpp_pkg::DIR_RESET;
            dir_c_q <= gpp_pkg::DIR_RESET;
            data_a_q <= gpp_pkg::DATA_RESET;
            data_b_q <= gpp_pkg::DATA_RESET;
            data_c_q <= gpp_pkg::DATA_RESET;
        end else if (sfr_req.wr) begin
            case (sfr_req.addr)
                gpp_pkg::SFR_DATA_A: data_a_q <= sfr_req.wdata;
                gpp_pkg::SFR_DATA_B: data_b_q <= sfr_req.wdata;
                gpp_pkg::SFR_DATA_C: data_c_q <= sfr_req.wdata;
                gpp_pkg::SFR_DIR_A: dir_a_q <= sfr_req.wdata;
                gpp_pkg::SFR_DIR_B: dir_b_q <= sfr_req.wdata;
                gpp_pkg::SFR_DIR_C: dir_c_q <= sfr_req.wdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // Pin synchroniser
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Keep tracking the pins, so release brings no stale level
            s1_q <= gp_pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= s3_q;
        end else begin
            s1_q <= gp_pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Change counts only once stages two and three agree
            for (int i = 0; i < gpp_pkg::NUM_PINS; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    lvl_q[i] <= s3_q[i];
                end
            end
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd) begin
            // Data reads return pin levels; unused bits read zero
            case (sfr_req.addr)
                gpp_pkg::SFR_DATA_A: sfr_rdata <= {lvl_q[3:0], 4'h0};
                gpp_pkg::SFR_DATA_B: sfr_rdata <= {lvl_q[9:8], 2'h0, lvl_q[7:4]};
                gpp_pkg::SFR_DATA_C: sfr_rdata <= {6'h00, lvl_q[11:10]};
                gpp_pkg::SFR_DIR_A: sfr_rdata <= dir_a_q;
                gpp_pkg::SFR_DIR_B: sfr_rdata <= dir_b_q;
                gpp_pkg::SFR_DIR_C: sfr_rdata <= dir_c_q;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // LCD claim, highest pin first
    // ****************************************
    always_comb begin
        for (int i = 0; i < gpp_pkg::NUM_PINS; i++) begin
            claim[i] = (32'(segment_count_select) > 32'(gpp_pkg::NUM_PINS - 1 - i));
        end
    end
    assign lcd_claim = claim;

    // ****************************************
    // Output drive
    // ****************************************
    always_comb begin
        for (int i = 0; i < gpp_pkg::NUM_PINS; i++) begin
            pin_out_d[i] = dout[i];
            pin_oe_d[i] = dir[i] & ~claim[i];
        end
        if (eeprom_pin_select && !claim[0]) begin
            pin_out_d[0] = eeprom_out[0];
            pin_out_d[1] = eeprom_out[1];
            pin_oe_d[0] = eeprom_oe[0];
            pin_oe_d[1] = eeprom_oe[1] & ~claim[1];
        end
        if (energy_pulse_enable && dir[2]) begin
            pin_out_d[2] = energy_pulse_out;
        end
        if (reactive_pulse_enable && dir[3]) begin
            pin_out_d[3] = reactive_pulse_out;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gp_pin_out <= 12'h000;
            gp_pin_oe <= 12'h000;
        end else begin
            gp_pin_out <= pin_out_d;
            gp_pin_oe <= pin_oe_d;
        end
    end

    assign eeprom_in = lvl_q[1:0];

    // ****************************************
    // Hook routing
    // ****************************************
    function automatic logic [2:0] hook_sel(input logic [23:0] f, input int k);
        hook_sel = f[3*k +: 3];
    endfunction

    always_comb begin
        hooks_d = '0;
        hi_rise = 1'b0;
        hi_fall = 1'b0;
        lo_rise = 1'b0;
        lo_fall = 1'b0;
        // Only the first eight indices (pins 4..11) have selectors
        for (int k = 0; k < gpp_pkg::HOOK_PINS; k++) begin
            if (!claim[k]) begin
                case (hook_sel(pin_hook_select, k))
                    gpp_pkg::SEL_CNT0: hooks_d.counter_zero_clock |= lvl_q[k];
                    gpp_pkg::SEL_CNT1: hooks_d.counter_one_clock |= lvl_q[k];
                    gpp_pkg::SEL_HI_RISE: hi_rise |= lvl_q[k];
                    gpp_pkg::SEL_LO_RISE: lo_rise |= lvl_q[k];
                    gpp_pkg::SEL_HI_FALL: hi_fall |= ~lvl_q[k];
                    gpp_pkg::SEL_LO_FALL: lo_fall |= ~lvl_q[k];
                    default: ;
                endcase
            end
        end
        hooks_d.hi_prio_irq_line = hi_rise | hi_fall;
        hooks_d.lo_prio_irq_line = lo_rise | lo_fall;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hooks <= '0;
            // Seed with the present level so no edge fires on release
            hi_prev_rise_q <= hi_rise;
            hi_prev_fall_q <= hi_fall;
            lo_prev_rise_q <= lo_rise;
            lo_prev_fall_q <= lo_fall;
        end else begin
            hooks <= hooks_d;
            hi_prev_rise_q <= hi_rise;
            hi_prev_fall_q <= hi_fall;
            lo_prev_rise_q <= lo_rise;
            lo_prev_fall_q <= lo_fall;
        end
    end

    // ****************************************
    // Interrupt flags
    // ****************************************
    logic hi_evt, lo_evt;
    // Falling edges arrive inverted, so both kinds become rising events
    assign hi_evt = (hi_rise & ~hi_prev_rise_q) | (hi_fall & ~hi_prev_fall_q);
    assign lo_evt = (lo_rise & ~lo_prev_rise_q) | (lo_fall & ~lo_prev_fall_q);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq0_flag <= 1'b0;
            irq1_flag <= 1'b0;
        end else begin
            // Set beats service clear in the same cycle
            if (hi_evt) begin
                irq0_flag <= 1'b1;
            end else if (irq0_ack) begin
                irq0_flag <= 1'b0;
            end
            if (lo_evt) begin
                irq1_flag <= 1'b1;
            end else if (irq1_ack) begin
                irq1_flag <= 1'b0;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_hi_edge;
        hi_evt;
    endsequence

    sequence s_lo_edge;
        lo_evt;
    endsequence

    // Service entry without a competing edge
    sequence s_hi_ack;
        irq0_ack && !hi_evt;
    endsequence

    sequence s_lo_ack;
        irq1_ack && !lo_evt;
    endsequence

    AST_IRQ0_SET: assert property (@(posedge clk) disable iff (!rst_n)
        s_hi_edge |=> irq0_flag)
        else $error("High-priority flag not set after edge");
    AST_IRQ1_SET: assert property (@(posedge clk) disable iff (!rst_n)
        s_lo_edge |=> irq1_flag)
        else $error("Low-priority flag not set after edge");
    AST_IRQ0_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        s_hi_ack |=> !irq0_flag)
        else $error("High-priority flag not cleared on service");
    AST_IRQ1_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        s_lo_ack |=> !irq1_flag)
        else $error("Low-priority flag not cleared on service");
    AST_IRQ0_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        irq0_flag && !irq0_ack |=> irq0_flag)
        else $error("High-priority flag dropped without service");
    AST_IRQ1_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        irq1_flag && !irq1_ack |=> irq1_flag)
        else $error("Low-priority flag dropped without service");
    AST_IRQ0_NOEVT: assert property (@(posedge clk) disable iff (!rst_n)
        !irq0_flag && !hi_evt |=> !irq0_flag)
        else $error("High-priority flag set without an edge");
    AST_IRQ1_NOEVT: assert property (@(posedge clk) disable iff (!rst_n)
        !irq1_flag && !lo_evt |=> !irq1_flag)
        else $error("Low-priority flag set without an edge");
    AST_HI_LINE: assert property (@(posedge clk) disable iff (!rst_n)
        s_hi_edge |=> hooks.hi_prio_irq_line)
        else $error("High-priority hook line low after edge");
    AST_LO_LINE: assert property (@(posedge clk) disable iff (!rst_n)
        s_lo_edge |=> hooks.lo_prio_irq_line)
        else $error("Low-priority hook line low after edge");

    AST_SEG_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        segment_count_select == 5'h03 |-> lcd_claim == 12'he00)
        else $error("Segment count claims wrong pin");
    AST_SEG_NONE: assert property (@(posedge clk) disable iff (!rst_n)
        segment_count_select == 5'h00 |-> lcd_claim == 12'h000)
        else $error("Zero segment count claims a pin");
    AST_SEG_ALL: assert property (@(posedge clk) disable iff (!rst_n)
        segment_count_select >= 5'h0c |-> lcd_claim == 12'hfff)
        else $error("Large segment count leaves a pin free");
    AST_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
        energy_pulse_enable && dir[2] |=> gp_pin_out[2] == $past(energy_pulse_out))
        else $error("Pulse pin not following engine");
    AST_VAR_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
        reactive_pulse_enable && dir[3] |=> gp_pin_out[3] == $past(reactive_pulse_out))
        else $error("Reactive pulse pin not following engine");
    AST_EE_OE: assert property (@(posedge clk) disable iff (!rst_n)
        eeprom_pin_select && !claim[0] |=> gp_pin_oe[0] == $past(eeprom_oe[0]))
        else $error("EEPROM pin enable not passed through");
    AST_EE_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        eeprom_pin_select && !claim[0] |=> gp_pin_out[1:0] == $past(eeprom_out))
        else $error("EEPROM pin data not passed through");
    AST_RESET_IN: assert property (@(posedge clk)
        !rst_n |=> gp_pin_oe == 12'h000)
        else $error("Pin driven after reset");
    AST_CNT0_OR: assert property (@(posedge clk) disable iff (!rst_n)
        hook_sel(pin_hook_select, 0) == gpp_pkg::SEL_CNT0 && !claim[0] && lvl_q[0]
        |=> hooks.counter_zero_clock)
        else $error("Counter hook missing pin level");
    AST_CNT1_OR: assert property (@(posedge clk) disable iff (!rst_n)
        hook_sel(pin_hook_select, 3) == gpp_pkg::SEL_CNT1 && !claim[3] && lvl_q[3]
        |=> hooks.counter_one_clock)
        else $error("Counter one hook missing pin level");
    AST_HOOK_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        pin_hook_select == 24'h000000 |=> hooks == '0)
        else $error("Hook active with no selector");
    AST_RD_DIR_A: assert property (@(posedge clk) disable iff (!rst_n)
        sfr_req.rd && sfr_req.addr == gpp_pkg::SFR_DIR_A |=> sfr_rdata == $past(dir_a_q))
        else $error("Direction read wrong");
    AST_RD_DATA_C: assert property (@(posedge clk) disable iff (!rst_n)
        sfr_req.rd && sfr_req.addr == gpp_pkg::SFR_DATA_C
        |=> sfr_rdata == {6'h00, $past(lvl_q[11:10])})
        else $error("Data read wrong");
    AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !sfr_req.rd |=> $stable(sfr_rdata))
        else $error("Read data changed without a read");

    // ****************************************
    // Per-pin checks
    // ****************************************
    // Pins 4 and 5 excluded while the EEPROM owns them
    for (genvar i = 0; i < gpp_pkg::NUM_PINS; i++) begin : g_pin_chk
        AST_DIR_OE: assert property (@(posedge clk) disable iff (!rst_n)
            !dir[i] && (i > 1 || !eeprom_pin_select) |=> !gp_pin_oe[i])
            else $error("Input pin drives");
        AST_OE_DIR: assert property (@(posedge clk) disable iff (!rst_n)
            dir[i] && !claim[i] && (i > 1 || !eeprom_pin_select) |=> gp_pin_oe[i])
            else $error("Output pin not driving");
        AST_LCD_OE: assert property (@(posedge clk) disable iff (!rst_n)
            claim[i] |=> !gp_pin_oe[i])
            else $error("LCD pin drives output");
        AST_DATA_OUT: assert property (@(posedge clk) disable iff (!rst_n)
            i > 3 && dir[i] |=> gp_pin_out[i] == $past(dout[i]))
            else $error("Pin output not following data register");
    end

endmodule

// ===== bench/gpp_board.sv
`timescale 1ns/100ps
// ****************************************
// Board side of the pins
// ****************************************
module gpp_board (
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_oe,
    input wire logic [11:0] ext_val,
    output logic [11:0] pin_in
);
    // Own driver wins, so a driven output reads back its level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// ===== bench/test_gp_pin_port_with_routing.sv
`timescale 1ns/100ps
module test_gp_pin_port_with_routing;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    gpp_pkg::gpp_sfr_req_t req = '0;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic [4:0] seg = 5'h00;
    logic [23:0] hsel = 24'h000000;
    logic pw_en, pv_en, ee_sel, pw_out, pv_out, ack0, ack1, irq0, irq1;
    logic [1:0] ee_out, ee_oe, ee_in;
    logic [11:0] ext, pin_in, pin_out, pin_oe, claim;
    gpp_pkg::gpp_hooks_t hooks;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    gpp_port dut (.clk(clk), .rst_n(rst_n), .sfr_req(req), .sfr_rdata(rdata),
        .segment_count_select(seg), .pin_hook_select(hsel), .energy_pulse_enable(pw_en),
        .reactive_pulse_enable(pv_en), .eeprom_pin_select(ee_sel),
        .energy_pulse_out(pw_out), .reactive_pulse_out(pv_out), .eeprom_out(ee_out),
        .eeprom_oe(ee_oe), .eeprom_in(ee_in), .irq0_ack(ack0), .irq1_ack(ack1),
        .gp_pin_in(pin_in), .gp_pin_out(pin_out), .gp_pin_oe(pin_oe), .lcd_claim(claim),
        .hooks(hooks), .irq0_flag(irq0), .irq1_flag(irq1));

    gpp_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext), .pin_in(pin_in));

    // ****************************************
    // Shared tasks
    // ****************************************
    task summarize;
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = {1'b1, 1'b0, a, d};
        @(negedge clk);
        req.wr = 1'b0;
    endtask

    // Read data stands until the next read, so one spare cycle is safe
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        req = {1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        req.rd = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task clr_irq;
        ack0 = 1'b1;
        ack1 = 1'b1;
        wait_n(1);
        ack0 = 1'b0;
        ack1 = 1'b0;
        wait_n(2);
        check({irq1, irq0}, 2'b00);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        check(pin_oe, 12'h000);
        rd(gpp_pkg::SFR_DIR_A, rv);
        check(rv & 8'hf0, 8'h00);
        rd(gpp_pkg::SFR_DIR_C, rv);
        check(rv & 8'h03, 8'h00);
    endtask

    task t_regs;
        wr(gpp_pkg::SFR_DIR_A, 8'hf0);
        wr(gpp_pkg::SFR_DATA_A, 8'ha0);
        wr(gpp_pkg::SFR_DIR_B, 8'hcf);
        wr(gpp_pkg::SFR_DATA_B, 8'h45);
        wr(gpp_pkg::SFR_DIR_C, 8'h03);
        wr(gpp_pkg::SFR_DATA_C, 8'h02);
        wr(8'h92, 8'hff);
        wait_n(6);
        check(pin_oe, 12'hfff);
        check(pin_out, 12'h95a);
        rd(gpp_pkg::SFR_DATA_A, rv);
        check(rv & 8'hf0, 8'ha0);
        rd(gpp_pkg::SFR_DATA_B, rv);
        check(rv & 8'hcf, 8'h45);
        rd(gpp_pkg::SFR_DATA_C, rv);
        check(rv & 8'h03, 8'h02);
        rd(gpp_pkg::SFR_DIR_B, rv);
        check(rv & 8'hcf, 8'hcf);
        rd(8'h55, rv);
        check(rv, 8'h00);
    endtask

    task t_lcd;
        seg = 5'h03;
        wait_n(2);
        check(claim, 12'he00);
        check(pin_oe, 12'h1ff);
        seg = 5'h0c;
        wait_n(2);
        check(claim, 12'hfff);
        check(pin_oe, 12'h000);
        seg = 5'h00;
        wr(gpp_pkg::SFR_DIR_A, 8'h00);
        wr(gpp_pkg::SFR_DIR_B, 8'h00);
        wr(gpp_pkg::SFR_DIR_C, 8'h00);
    endtask

    task t_count;
        hsel = {12'h000, gpp_pkg::SEL_CNT1, gpp_pkg::SEL_CNT0, gpp_pkg::SEL_RESERVED,
            gpp_pkg::SEL_CNT0};
        ext[11:8] = 4'hf;
        ext[1] = 1'b1;
        wr(gpp_pkg::SFR_DIR_A, 8'h80);
        wr(gpp_pkg::SFR_DATA_A, 8'h00);
        wait_n(8);
        check(hooks, 4'h0);
        ext[2] = 1'b1;
        wait_n(8);
        check({hooks.counter_one_clock, hooks.counter_zero_clock}, 2'b01);
        ext[2] = 1'b0;
        wr(gpp_pkg::SFR_DATA_A, 8'h80);
        wait_n(8);
        check({hooks.counter_one_clock, hooks.counter_zero_clock}, 2'b10);
        wr(gpp_pkg::SFR_DIR_A, 8'h00);
        hsel = 24'h000000;
    endtask

    // Idle level first, then a clear, so stray edges from the selector change are dropped
    task t_irq;
        for (int i = 4; i < 8; i++) begin
            hsel = {18'h00000, 3'(i), 3'h0};
            ext[1] = (i >= 6);
            wait_n(8);
            clr_irq();
            ext[1] = ~ext[1];
            wait_n(8);
            check({irq1, irq0}, (i % 2 == 1) ? 2'b10 : 2'b01);
            check({hooks.lo_prio_irq_line, hooks.hi_prio_irq_line},
                (i % 2 == 1) ? 2'b10 : 2'b01);
        end
        clr_irq();
        hsel = 24'h000000;
    endtask

    task t_pulse;
        wr(gpp_pkg::SFR_DIR_A, 8'hc0);
        wr(gpp_pkg::SFR_DATA_A, 8'h00);
        pw_en = 1'b1;
        pv_en = 1'b1;
        pw_out = 1'b1;
        wait_n(2);
        check(pin_out[3:2], 2'b01);
        pw_out = 1'b0;
        pv_out = 1'b1;
        wait_n(2);
        check(pin_out[3:2], 2'b10);
        pw_en = 1'b0;
        pv_en = 1'b0;
        wait_n(2);
        check(pin_out[3:2], 2'b00);
        wr(gpp_pkg::SFR_DIR_A, 8'h00);
    endtask

    task t_eeprom;
        ee_sel = 1'b1;
        ee_oe = 2'b01;
        ee_out = 2'b01;
        ext[1] = 1'b1;
        wait_n(8);
        check({pin_out[0], pin_oe[1:0]}, 3'b101);
        check(ee_in, 2'b11);
        ee_sel = 1'b0;
        wait_n(2);
        check(pin_oe[1:0], 2'b00);
    endtask

    // Second reset with a pin high on a rising hook: no flag may follow
    task t_rst2;
        hsel = {18'h00000, gpp_pkg::SEL_HI_RISE, 3'h0};
        ext[1] = 1'b1;
        wr(gpp_pkg::SFR_DIR_B, 8'hcf);
        wait_n(8);
        clr_irq();
        rst_n = 1'b0;
        wait_n(3);
        rst_n = 1'b1;
        wait_n(8);
        check(pin_oe, 12'h000);
        check({irq1, irq0}, 2'b00);
        check(hooks.hi_prio_irq_line, 1'b1);
        hsel = 24'h000000;
    endtask

    // Generous ceiling; the full run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        {pw_en, pv_en, ee_sel, pw_out, pv_out, ack0, ack1} = 7'h00;
        ee_out = 2'b00;
        ee_oe = 2'b00;
        ext = 12'h000;
        wait_n(12);
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_lcd();
        t_count();
        t_irq();
        t_pulse();
        t_eeprom();
        t_rst2();
        summarize();
    end
endmodule
